// *** cfg_word_pkg.sv ***
// Package for the configuration word decoder: map, fields, encodings
package cfg_word_pkg;

  // Register byte addresses of this block's own bus map
  localparam logic [7:0] ADDR_WORD_ONE = 8'h00;
  localparam logic [7:0] ADDR_WORD_TWO = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_PROG = 8'h10;
  localparam logic [7:0] ADDR_WP_SIZE = 8'h14;

  // Word one field positions
  localparam int DEBUG_BIT = 13;
  localparam int LVP_BIT = 12;
  localparam int FCM_BIT = 11;
  localparam int SWO_BIT = 10;
  localparam int BOR_LSB = 8;
  localparam int CPD_BIT = 7;
  localparam int CP_BIT = 6;
  localparam int RST_BIT = 5;
  localparam int PUD_BIT = 4;
  localparam int WDT_BIT = 3;
  localparam int OSC_LSB = 0;
  // Word two field positions
  localparam int WRP_LSB = 9;
  localparam int BTH_BIT = 8;

  // Unimplemented bits read as one; word two low byte likewise
  localparam logic [15:0] WORD_ONE_UNIMPL = 16'hC000;
  localparam logic [15:0] WORD_TWO_UNIMPL = 16'hF8FF;
  // Erased (unprogrammed) values after reset
  localparam logic [15:0] WORD_ONE_RESET = 16'hFFFF;
  localparam logic [15:0] WORD_TWO_RESET = 16'hFFFF;

  // Control register bits
  localparam int CTRL_SBOR_BIT = 0;
  localparam int CTRL_SWDT_BIT = 1;
  localparam int CTRL_SLEEP_BIT = 2;
  // Program register: bit 16 selects word two
  localparam int PROG_SEL_BIT = 16;

  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    BOR_OFF = 2'h0,
    BOR_SOFT = 2'h1,
    BOR_RUN_ONLY = 2'h2,
    BOR_ALWAYS = 2'h3
  } brownout_policy_e;

  typedef enum logic [2:0] {
    low_power_crystal = 3'h0,
    standard_crystal = 3'h1,
    fast_crystal = 3'h2,
    external_clock_in = 3'h3,
    internal_osc_io = 3'h4,
    internal_osc_clock_output_pin = 3'h5,
    rc_osc_io = 3'h6,
    rc_osc_clock_output_pin = 3'h7
  } oscillator_select_e;

  localparam logic [1:0] WRP_OFF = 2'h3;

  // Decoded settings bundle
  typedef struct packed {
    logic debug_pins_gpio;
    logic prog_entry_pin_en;
    logic hv_prog_required;
    logic clock_monitor_enable;
    logic clock_switchover_enable;
    logic brownout_active;
    logic data_protect_active;
    logic program_protect_active;
    logic reset_pin_is_reset;
    logic internal_reset_n;
    logic powerup_delay_timer_en;
    logic watchdog_run;
    oscillator_select_e oscillator_select;
    logic clock_output_pin_en;
    logic clock_input_pin_io;
    logic osc_pins_io;
    logic internal_osc_stop;
    logic brownout_threshold_sel;
    logic [1:0] self_write_protect;
  } cfg_settings_s;

endpackage : cfg_word_pkg

// *** config_word_decoder.sv ***
// Configuration word store and decoder with AXI4-Lite register access
// Contract
// - Debug field one makes programming pins GPIO
// - Low-voltage field enables programming entry pin
// - Clock monitor follows its field
// - Clock switchover follows its field
// - Brown-out policy selects four modes
// - Data protection active when field zero
// - Program protection active when field zero
// - Reset pin function or internal reset inactive
// - Power-up timer enabled when field zero
// - Watchdog forced on, else software enable
// - Codes 111/110 select RC oscillator
// - Codes 101/100 select internal oscillator
// - Brown-out never enables power-up timer
// - Unprotecting data erases data memory
// - Unprotecting program erases program memory
// - External reset stops internal/RC oscillator
// - Unimplemented word bits read one
// - Word two holds self-write protection field
// - Value 11 unprotected, else lower range protected
// - Word two bit 8 selects brown-out threshold
`timescale 1ns/1ns
module config_word_decoder
  import cfg_word_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins from outside the clock domain
  input wire logic external_reset_n,
  // Firmware self-write check
  input wire logic [ADDR_W-1:0] self_write_addr,
  output logic self_write_allowed,
  // Decoded settings
  output cfg_settings_s settings,
  // Erase pulses to the memories
  output logic data_erase,
  output logic program_erase
);

  logic [15:0] word_one_r;
  logic [15:0] word_two_r;
  logic soft_bor_r;
  logic soft_wdt_r;
  logic sleep_r;
  logic [ADDR_W-1:0] wp_bound_r;
  logic [1:0] ext_rst_sync_r;
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic data_erase_r;
  logic program_erase_r;
  logic [1:0] bresp_r;
  logic bvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic rvalid_r;
  logic do_write;
  logic [15:0] prog_val;
  logic prog_word_two;
  logic prog_hit;
  cfg_settings_s set_nxt;

  // Byte-lane merge of a 16-bit word
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] st);
    logic [15:0] res;
    res = old;
    if (st[0]) res[7:0] = wd[7:0];
    if (st[1]) res[15:8] = wd[15:8];
    return res;
  endfunction : merge16

  // Internal or RC oscillator selected
  function automatic logic osc_is_rc_or_int(input logic [2:0] sel);
    return sel[2];
  endfunction : osc_is_rc_or_int

  // External reset pin is asynchronous
  always_ff @(posedge mclk) begin
    if (!rst_n) ext_rst_sync_r <= 2'h3;
    else ext_rst_sync_r <= {ext_rst_sync_r[0], external_reset_n};
  end

  // Write channel capture; address and data in either order
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign do_write = aw_held_r && w_held_r && !bvalid_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      aw_held_r <= 1'b0;
      awaddr_r <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end

  // Write response; only the programming register accepts word updates
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bvalid_r <= 1'b0;
      bresp_r <= AXI_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r <= (awaddr_r == ADDR_PROG || awaddr_r == ADDR_CTRL ||
                  awaddr_r == ADDR_WP_SIZE) ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // Programming-interface access: words are read-only from the bus map
  assign prog_hit = do_write && awaddr_r == ADDR_PROG;
  assign prog_word_two = wdata_r[PROG_SEL_BIT];
  assign prog_val = prog_word_two
    ? merge16(word_two_r, wdata_r, wstrb_r) | WORD_TWO_UNIMPL
    : merge16(word_one_r, wdata_r, wstrb_r) | WORD_ONE_UNIMPL;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      word_one_r <= WORD_ONE_RESET;
      word_two_r <= WORD_TWO_RESET;
    end else if (prog_hit && prog_word_two) begin
      word_two_r <= prog_val;
    end else if (prog_hit) begin
      word_one_r <= prog_val;
    end
  end

  // Protection release erases the protected memory
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      data_erase_r <= 1'b0;
      program_erase_r <= 1'b0;
    end else begin
      data_erase_r <= prog_hit && !prog_word_two &&
        !word_one_r[CPD_BIT] && prog_val[CPD_BIT];
      program_erase_r <= prog_hit && !prog_word_two &&
        !word_one_r[CP_BIT] && prog_val[CP_BIT];
    end
  end
  assign data_erase = data_erase_r;
  assign program_erase = program_erase_r;

  // Software control bits: brown-out and watchdog soft enables, sleep
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      soft_bor_r <= 1'b0;
      soft_wdt_r <= 1'b0;
      sleep_r <= 1'b0;
    end else if (do_write && awaddr_r == ADDR_CTRL && wstrb_r[0]) begin
      soft_bor_r <= wdata_r[CTRL_SBOR_BIT];
      soft_wdt_r <= wdata_r[CTRL_SWDT_BIT];
      sleep_r <= wdata_r[CTRL_SLEEP_BIT];
    end
  end

  // Protected range top; size depends on memory variant
  always_ff @(posedge mclk) begin
    if (!rst_n) wp_bound_r <= '0;
    else if (do_write && awaddr_r == ADDR_WP_SIZE)
      wp_bound_r <= wdata_r[ADDR_W-1:0];
  end

  // Decode
  always_comb begin
    set_nxt = '0;
    set_nxt.debug_pins_gpio = word_one_r[DEBUG_BIT];
    set_nxt.prog_entry_pin_en = word_one_r[LVP_BIT];
    set_nxt.hv_prog_required = !word_one_r[LVP_BIT];
    set_nxt.clock_monitor_enable = word_one_r[FCM_BIT];
    set_nxt.clock_switchover_enable = word_one_r[SWO_BIT];
    unique case (brownout_policy_e'(word_one_r[BOR_LSB +: 2]))
      BOR_ALWAYS: set_nxt.brownout_active = 1'b1;
      BOR_RUN_ONLY: set_nxt.brownout_active = !sleep_r;
      BOR_SOFT: set_nxt.brownout_active = soft_bor_r;
      BOR_OFF: set_nxt.brownout_active = 1'b0;
    endcase
    set_nxt.data_protect_active = !word_one_r[CPD_BIT];
    set_nxt.program_protect_active = !word_one_r[CP_BIT];
    set_nxt.reset_pin_is_reset = word_one_r[RST_BIT];
    set_nxt.internal_reset_n = word_one_r[RST_BIT]
      ? ext_rst_sync_r[1] : 1'b1;
    // Own field only; brown-out takes no part
    set_nxt.powerup_delay_timer_en = !word_one_r[PUD_BIT];
    set_nxt.watchdog_run = word_one_r[WDT_BIT] || soft_wdt_r;
    set_nxt.oscillator_select =
      oscillator_select_e'(word_one_r[OSC_LSB +: 3]);
    unique case (set_nxt.oscillator_select)
      rc_osc_clock_output_pin: set_nxt.clock_output_pin_en = 1'b1;
      rc_osc_io: set_nxt.clock_output_pin_en = 1'b0;
      internal_osc_clock_output_pin: begin
        set_nxt.clock_output_pin_en = 1'b1;
        set_nxt.clock_input_pin_io = 1'b1;
      end
      internal_osc_io: begin
        set_nxt.clock_input_pin_io = 1'b1;
        set_nxt.osc_pins_io = 1'b1;
      end
      external_clock_in: set_nxt.clock_output_pin_en = 1'b0;
      fast_crystal, standard_crystal,
      low_power_crystal: set_nxt.osc_pins_io = 1'b0;
    endcase
    set_nxt.internal_osc_stop = word_one_r[RST_BIT] && !ext_rst_sync_r[1]
      && osc_is_rc_or_int(word_one_r[OSC_LSB +: 3]);
    set_nxt.brownout_threshold_sel = word_two_r[BTH_BIT];
    set_nxt.self_write_protect = word_two_r[WRP_LSB +: 2];
  end

  // Settings registered so every data output comes from a flip-flop
  always_ff @(posedge mclk) begin
    if (!rst_n) settings <= '0;
    else settings <= set_nxt;
  end

  // Lower range below the bound is closed to self-writes
  always_ff @(posedge mclk) begin
    if (!rst_n) self_write_allowed <= 1'b0;
    else self_write_allowed <= (word_two_r[WRP_LSB +: 2] == WRP_OFF) ||
      (self_write_addr >= wp_bound_r);
  end

  // Read channel, one beat in flight
  assign s_axi_arready = !rvalid_r;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r <= AXI_OKAY;
      unique case (s_axi_araddr)
        ADDR_WORD_ONE: rdata_r <= {16'h0000, word_one_r};
        ADDR_WORD_TWO: rdata_r <= {16'h0000, word_two_r};
        ADDR_CTRL: rdata_r <= {29'h0, sleep_r, soft_wdt_r, soft_bor_r};
        ADDR_STATUS: rdata_r <= {24'h0, settings.watchdog_run,
          settings.brownout_active, settings.internal_osc_stop,
          settings.internal_reset_n, settings.data_protect_active,
          settings.program_protect_active,
          settings.powerup_delay_timer_en, self_write_allowed};
        ADDR_WP_SIZE: rdata_r <= 32'(wp_bound_r);
        default: begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

endmodule : config_word_decoder

// *** cfg_word_monitor.sv ***
// Checker for the decoded configuration settings
`timescale 1ns/1ns
module cfg_word_monitor
  import cfg_word_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Decoded outputs
  input wire cfg_settings_s settings,
  input wire logic self_write_allowed,
  input wire logic data_erase,
  input wire logic program_erase
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Settings still show reset zeros on the first edge after release
  logic live_r;
  always_ff @(posedge mclk) begin
    live_r <= rst_n;
  end
  a_prog_entry_pair: assert property (
    live_r |-> settings.prog_entry_pin_en != settings.hv_prog_required)
    else $error("programming entry and high voltage flags agree");
  a_osc_stop_mode: assert property (
    live_r && settings.internal_osc_stop |->
    settings.oscillator_select >= internal_osc_io)
    else $error("oscillator stopped in a crystal or clock-in mode");
  a_reset_tied_off: assert property (
    live_r && !settings.reset_pin_is_reset |-> settings.internal_reset_n)
    else $error("internal reset active while pin is an input");
  a_rc_clock_out: assert property (
    live_r && settings.oscillator_select == rc_osc_clock_output_pin |->
    settings.clock_output_pin_en)
    else $error("clock output missing in RC clock-out mode");
  a_crystal_no_clock_output_pin: assert property (
    live_r && settings.oscillator_select < internal_osc_io |->
    !settings.clock_output_pin_en)
    else $error("clock output driven in crystal or clock-in mode");
  a_data_erase_pulse: assert property (
    data_erase |=> !data_erase)
    else $error("data erase longer than one cycle");
  a_prog_erase_pulse: assert property (
    program_erase |=> !program_erase)
    else $error("program erase longer than one cycle");
  a_wp_off_allows: assert property (
    live_r && settings.self_write_protect == WRP_OFF |->
    self_write_allowed)
    else $error("self write refused with protection off");
  c_data_erase: cover property (data_erase);
  c_prog_erase: cover property (program_erase);
  c_osc_stop: cover property (settings.internal_osc_stop);
endmodule : cfg_word_monitor

// *** config_word_decoder_test.sv ***
// Self-checking bench for the configuration word decoder
`timescale 1ns/1ns
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module config_word_decoder_test import cfg_word_pkg::*; ();
  logic mclk = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic external_reset_n = 1, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, self_write_allowed;
  logic data_erase, program_erase;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] self_write_addr = 16'h0000;
  cfg_settings_s settings;
  int failures = 0, cmp_count = 0, de_n = 0, pe_n = 0, i;
  wire [11:0] f = {settings.debug_pins_gpio, settings.prog_entry_pin_en,
    settings.hv_prog_required, settings.clock_monitor_enable,
    settings.clock_switchover_enable, settings.brownout_active,
    settings.data_protect_active, settings.program_protect_active,
    settings.reset_pin_is_reset, settings.internal_reset_n,
    settings.powerup_delay_timer_en, settings.watchdog_run};
  config_word_decoder config_word_decoder_i (.*);
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk) begin
    de_n += (data_erase === 1'b1);
    pe_n += (program_erase === 1'b1);
  end
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic guard(input int n);
    if (n >= 40) begin
      failures++;
      complete_run();
    end
  endtask : guard
  // Ends two edges past the response so registered settings have landed
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (s_axi_bvalid) break;
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end
    guard(n);
    rsp = s_axi_bresp;
    s_axi_bready <= 0;
    repeat (2) @(posedge mclk);
  endtask : wr
  task automatic rdt(input logic [7:0] a);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (s_axi_rvalid) break;
      if (s_axi_arready) s_axi_arvalid <= 0;
    end
    guard(n);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge mclk);
  endtask : rdt
  task automatic prog(input logic sel, input logic [15:0] w);
    wr(ADDR_PROG, {15'h0000, sel, w});
  endtask : prog
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1;
    @(posedge mclk);
    rdt(ADDR_WORD_ONE);
    `CHK("word one", 32'h0000FFFF, rd)
    `CHK("flags erased", 12'hDCD, f)
    `CHK("threshold", 1'b1, settings.brownout_threshold_sel)
    prog(0, 16'h0000);
    `CHK("prog resp", AXI_OKAY, rsp)
    rdt(ADDR_WORD_ONE);
    `CHK("word one", 32'h0000C000, rd)
    `CHK("flags zero", 12'h236, f)
    wr(ADDR_CTRL, 32'h2);
    `CHK("soft watchdog", 1'b1, settings.watchdog_run)
    prog(0, 16'h0080);
    `CHK("data erase", {32'd1, 32'd0}, {de_n, pe_n})
    prog(0, 16'h00C0);
    `CHK("prog erase", {32'd1, 32'd1}, {de_n, pe_n})
    for (i = 0; i < 4; i++) begin
      prog(0, {6'h00, i[1:0], 8'hC0});
      wr(ADDR_CTRL, 32'h1);
      `CHK("bor awake", i != 0, settings.brownout_active)
      wr(ADDR_CTRL, 32'h4);
      `CHK("bor sleep", i == 3, settings.brownout_active)
    end
    for (i = 0; i < 8; i++) begin
      prog(0, 16'h3FF8 | i[2:0]);
      `CHK("osc", i[2:0], settings.oscillator_select)
      `CHK("clock_output_pin", i == 5 || i == 7, settings.clock_output_pin_en)
      `CHK("cin io", i[2:1] == 2'h2, settings.clock_input_pin_io)
      `CHK("pins io", i == 4, settings.osc_pins_io)
      external_reset_n <= 0;
      repeat (4) @(posedge mclk);
      `CHK("osc stop", i[2], settings.internal_osc_stop)
      `CHK("reset in", 1'b0, settings.internal_reset_n)
      external_reset_n <= 1;
      repeat (4) @(posedge mclk);
    end
    `CHK("no extra erase", {32'd1, 32'd1}, {de_n, pe_n})
    prog(0, 16'h3FDC);
    external_reset_n <= 0;
    repeat (4) @(posedge mclk);
    `CHK("reset tied", 1'b1, settings.internal_reset_n)
    external_reset_n <= 1;
    prog(1, 16'h0000);
    rdt(ADDR_WORD_TWO);
    `CHK("word two", 32'h0000F8FF, rd)
    `CHK("wp field", 2'h0, settings.self_write_protect)
    `CHK("threshold", 1'b0, settings.brownout_threshold_sel)
    wr(ADDR_WP_SIZE, 32'h00000100);
    self_write_addr <= 16'h00FF;
    repeat (2) @(posedge mclk);
    `CHK("wp below", 1'b0, self_write_allowed)
    self_write_addr <= 16'h0100;
    repeat (2) @(posedge mclk);
    `CHK("wp at top", 1'b1, self_write_allowed)
    self_write_addr <= 16'h00FF;
    prog(1, 16'hFFFF);
    `CHK("wp off", 1'b1, self_write_allowed)
    wr(ADDR_WORD_ONE, 32'h0);
    `CHK("ro write", AXI_SLVERR, rsp)
    rdt(8'h1C);
    `CHK("unmapped", {AXI_SLVERR, 32'h0}, {rsp, rd})
    rdt(ADDR_WP_SIZE);
    `CHK("wp size", {AXI_OKAY, 32'h00000100}, {rsp, rd})
    // Mid-run reset returns the words to the erased state
    rst_n <= 0;
    repeat (2) @(posedge mclk);
    rst_n <= 1;
    @(posedge mclk);
    rdt(ADDR_WORD_ONE);
    `CHK("word one reset", 32'h0000FFFF, rd)
    complete_run();
  end
endmodule : config_word_decoder_test
bind config_word_decoder cfg_word_monitor cfg_word_monitor_i (.mclk(mclk),
  .rst_n(rst_n), .settings(settings), .self_write_allowed(self_write_allowed),
  .data_erase(data_erase), .program_erase(program_erase));
